// ==== spi_host_controller.sv ====
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "spi_port_cfg.svh"
module spi_host_controller (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  spi_link_if.host         link,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    spi_port_pkg::host_state_t st;
    logic [1:0]  so_s;
    logic [1:0]  sd_s;
    logic [7:0]  hdr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        lsb;
    logic        four;
    logic [5:0]  nbits;
    logic [5:0]  cnt;
    logic [3:0]  div;
    logic        sclk;
    logic        sen_n;
    logic        dout;
    logic        oe;
    logic        samp;
    logic [4:0]  sidx;
  } host_t;

  host_t s_r;
  host_t s_nxt;
  logic  acc;
  logic  tick;
  logic  in_bit;
  logic  [31:0] rd_mux;

  // position of serial bit k inside its byte lane of wdata or rdata
  function automatic logic [4:0] data_idx(input logic [5:0] k,
                                          input logic       lsb);
    logic [2:0] b;
    b = lsb ? k[2:0] : 3'(3'h7 - k[2:0]);
    data_idx = {2'(k[5:3] - 3'h1), b};
  endfunction : data_idx

  // header then data, each byte shifted in the chosen order
  function automatic logic out_bit(input host_t s);
    logic [4:0] idx;
    idx = data_idx(s.cnt, s.lsb);
    if (s.cnt < 6'd8)
      out_bit = s.hdr[idx[2:0]];
    else
      out_bit = s.wdata[idx];
  endfunction : out_bit

  assign acc    = i_psel & i_penable;
  assign tick   = s_r.div == 4'(`SCLK_HALF_CYC - 1);
  assign in_bit = s_r.four ? s_r.so_s[1] : s_r.sd_s[1];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.so_s = {s_r.so_s[0], link.serial_out_line_i};
    s_nxt.sd_s = {s_r.sd_s[0], link.sdio_i};
    if (s_r.samp)
    begin
      // taken a cycle after the rise: the answer leaves the synchroniser
      // only then, and stands until the device's next fall
      s_nxt.rdata[s_r.sidx] = in_bit;
      s_nxt.samp            = 1'b0;
    end
    if (acc && i_pwrite && s_r.st == spi_port_pkg::H_IDLE)
    begin
      unique case (i_paddr)
        `HOST_CTRL_OFS:
        begin
          // ctrl: [7:0] header, [8] lsb first, [9] four wire, [31] go
          s_nxt.hdr  = i_pwdata[7:0];
          s_nxt.lsb  = i_pwdata[8];
          s_nxt.four = i_pwdata[9];
          if (i_pwdata[31])
          begin
            s_nxt.st    = spi_port_pkg::H_RUN;
            s_nxt.sen_n = 1'b0;
            s_nxt.cnt   = 6'h0;
            s_nxt.div   = 4'h0;
            s_nxt.nbits = 6'(6'd16 + {i_pwdata[6:5], 3'b000});
            // first header bit must stand before the first rise
            s_nxt.dout  = i_pwdata[8] ? i_pwdata[0] : i_pwdata[7];
            s_nxt.oe    = 1'b1;
            s_nxt.rdata = 32'h0;
          end
        end
        `HOST_WDATA_OFS:
          s_nxt.wdata = i_pwdata;
        default:
          s_nxt.st = s_r.st;
      endcase
    end
    unique case (s_r.st)
      spi_port_pkg::H_IDLE:
        s_nxt.sclk = 1'b0;
      spi_port_pkg::H_RUN:
      begin
        s_nxt.div = tick ? 4'h0 : 4'(s_r.div + 4'h1);
        if (tick)
        begin
          s_nxt.sclk = ~s_r.sclk;
          if (!s_r.sclk)
          begin
            // rising edge: device samples now, host samples read data
            if (s_r.cnt >= 6'd8 && s_r.hdr[`HDR_RW_BIT])
            begin
              s_nxt.samp = 1'b1;
              s_nxt.sidx = data_idx(s_r.cnt, s_r.lsb);
            end
            s_nxt.cnt = 6'(s_r.cnt + 6'h1);
            if (6'(s_r.cnt + 6'h1) == s_r.nbits)
              s_nxt.st = spi_port_pkg::H_END;
          end
          else
          begin
            s_nxt.dout = out_bit(s_r);
            if (s_r.cnt == 6'd8 && s_r.hdr[`HDR_RW_BIT])
              s_nxt.oe = 1'b0;
          end
        end
      end
      spi_port_pkg::H_END:
      begin
        s_nxt.div = 4'(s_r.div + 4'h1);
        if (tick)
        begin
          s_nxt.sclk  = 1'b0;
          s_nxt.sen_n = 1'b1;
          s_nxt.oe    = 1'b0;
          s_nxt.st    = spi_port_pkg::H_IDLE;
        end
      end
      default:
        s_nxt.st = spi_port_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r       <= '0;
      s_r.sen_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************
  // apb read side
  // ****************************************
  always_comb
  begin
    unique case (i_paddr)
      `HOST_CTRL_OFS:  rd_mux = {22'h0, s_r.four, s_r.lsb, s_r.hdr};
      `HOST_WDATA_OFS: rd_mux = s_r.wdata;
      `HOST_RDATA_OFS: rd_mux = s_r.rdata;
      `HOST_STAT_OFS:  rd_mux = {31'h0, s_r.st != spi_port_pkg::H_IDLE};
      default:         rd_mux = 32'h0;
    endcase
  end

  assign o_prdata  = (acc && !i_pwrite) ? rd_mux : 32'h0;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & (i_paddr[11:4] != 8'h00 || i_paddr[1:0] != 2'b00);

  assign link.sclk          = s_r.sclk;
  assign link.port_select_n = s_r.sen_n;
  assign link.sdio_host_o   = s_r.dout;
  assign link.sdio_host_oe  = s_r.oe;

endmodule : spi_host_controller

// ==== spi_port_cfg.svh ====
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH
// serial_port_options register
`define SPO_ADDR          5'h00
`define SPO_RESET         8'h00
`define SPO_FOUR_WIRE_BIT 7
`define SPO_LSB_FIRST_BIT 6
// header field positions (header seen as msb-first byte)
`define HDR_RW_BIT        7
`define HDR_CNT_HI        6
`define HDR_CNT_LO        5
`define HDR_ADDR_HI       4
// host apb register offsets
`define HOST_CTRL_OFS     12'h000
`define HOST_WDATA_OFS    12'h004
`define HOST_RDATA_OFS    12'h008
`define HOST_STAT_OFS     12'h00c
// serial clock divider: half period in i_mclk cycles (80 ns period)
`define SCLK_HALF_NS      40
`define MCLK_NS           8
`define SCLK_HALF_CYC     (`SCLK_HALF_NS / `MCLK_NS)
`endif

// ==== spi_port_pkg.sv ====
package spi_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN  = 2'b01,
    H_END  = 2'b10
  } host_state_t;
endpackage : spi_port_pkg

// ==== spi_link_if.sv ====
`timescale 1ns/1ns
interface spi_link_if;
  logic sclk;
  logic port_select_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic serial_out_line_o;
  logic serial_out_line_oe;
  logic sdio_i;
  logic serial_out_line_i;

  // wire level: pulled high when nobody drives
  assign sdio_i = sdio_dev_oe ? sdio_dev_o :
                  (sdio_host_oe ? sdio_host_o : 1'b1);
  assign serial_out_line_i = serial_out_line_oe ? serial_out_line_o : 1'b1;

  modport dev (
    input  sclk,
    input  port_select_n,
    input  sdio_i,
    output sdio_dev_o,
    output sdio_dev_oe,
    output serial_out_line_o,
    output serial_out_line_oe
  );

  modport host (
    output sclk,
    output port_select_n,
    output sdio_host_o,
    output sdio_host_oe,
    input  sdio_i,
    input  serial_out_line_i
  );
endinterface : spi_link_if

// ==== spi_register_access_port.sv ====
`timescale 1ns/1ns
`include "spi_port_cfg.svh"
module spi_register_access_port #(
  parameter int NREG = 32
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  spi_link_if.dev         link,
  input  wire logic [4:0] i_reg_addr,
  output logic      [7:0] o_reg_data,
  output logic            o_four_wire,
  output logic            o_lsb_first,
  output logic            o_busy
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0]              sclk_s;
    logic [1:0]              sen_s;
    logic [1:0]              sdi_s;
    logic                    sclk_d;
    spi_port_pkg::dev_state_t st;
    logic [2:0]              bitn;
    logic [1:0]              bytes_left;
    logic                    rd;
    logic [4:0]              addr;
    logic [7:0]              sh;
    logic [NREG*8-1:0]       regs;
    logic                    dout;
    logic                    dout_en;
    logic [7:0]              rdout;
  } dev_t;

  dev_t s_r;
  dev_t s_nxt;

  function automatic logic [4:0] step_addr(input logic [4:0] a,
                                           input logic       lsb);
    step_addr = lsb ? 5'(a + 5'h01) : 5'(a - 5'h01);
  endfunction : step_addr

  logic       rise;
  logic       fall;
  logic       sen_n;
  logic       sdi;
  logic       lsb;
  logic       four;
  logic [7:0] hdr;
  logic [7:0] cur;

  assign sen_n = s_r.sen_s[1];
  assign sdi   = s_r.sdi_s[1];
  assign rise  = s_r.sclk_s[1] & ~s_r.sclk_d;
  assign fall  = ~s_r.sclk_s[1] & s_r.sclk_d;
  assign four  = s_r.regs[`SPO_ADDR*8 + `SPO_FOUR_WIRE_BIT];
  assign lsb   = s_r.regs[`SPO_ADDR*8 + `SPO_LSB_FIRST_BIT];
  assign cur   = s_r.regs[s_r.addr*8 +: 8];

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    hdr   = 8'h00;
    s_nxt.sclk_s = {s_r.sclk_s[0], link.sclk};
    s_nxt.sen_s  = {s_r.sen_s[0], link.port_select_n};
    s_nxt.sdi_s  = {s_r.sdi_s[0], link.sdio_i};
    s_nxt.sclk_d = s_r.sclk_s[1];
    if (sen_n)
    begin
      // partial byte discarded, port waits for a fresh header
      s_nxt.st      = spi_port_pkg::ST_HDR;
      s_nxt.bitn    = 3'h0;
      s_nxt.dout_en = 1'b0;
    end
    else
    begin
      unique case (s_r.st)
        spi_port_pkg::ST_IDLE:
          s_nxt.st = spi_port_pkg::ST_HDR;
        spi_port_pkg::ST_HDR:
          if (rise)
          begin
            s_nxt.sh   = lsb ? {sdi, s_r.sh[7:1]} : {s_r.sh[6:0], sdi};
            s_nxt.bitn = 3'(s_r.bitn + 3'h1);
            if (s_r.bitn == 3'h7)
            begin
              // shift direction already lands the first bit in place
              hdr = s_nxt.sh;
              s_nxt.rd   = hdr[`HDR_RW_BIT];
              s_nxt.bytes_left = hdr[`HDR_CNT_HI:`HDR_CNT_LO];
              s_nxt.addr = hdr[`HDR_ADDR_HI:0];
              s_nxt.st   = spi_port_pkg::ST_DATA;
              s_nxt.rdout = s_r.regs[hdr[`HDR_ADDR_HI:0]*8 +: 8];
            end
          end
        spi_port_pkg::ST_DATA:
          if (s_r.rd)
          begin
            if (fall)
            begin
              // first falling edge after the header presents the byte's first bit (bit 7 msb first, bit 0 lsb first)
              s_nxt.dout    = lsb ? s_r.rdout[s_r.bitn] :
                                    s_r.rdout[3'h7 - s_r.bitn];
              s_nxt.dout_en = 1'b1;
              s_nxt.bitn    = 3'(s_r.bitn + 3'h1);
              if (s_r.bitn == 3'h7)
              begin
                s_nxt.addr  = step_addr(s_r.addr, lsb);
                s_nxt.rdout = s_r.regs[step_addr(s_r.addr, lsb)*8 +: 8];
                s_nxt.bytes_left = 2'(s_r.bytes_left - 2'h1);
              end
            end
          end
          else if (rise)
          begin
            s_nxt.sh   = lsb ? {sdi, s_r.sh[7:1]} : {s_r.sh[6:0], sdi};
            s_nxt.bitn = 3'(s_r.bitn + 3'h1);
            if (s_r.bitn == 3'h7)
            begin
              s_nxt.regs[s_r.addr*8 +: 8] = s_nxt.sh;
              s_nxt.addr = step_addr(s_r.addr, lsb);
              s_nxt.bytes_left = 2'(s_r.bytes_left - 2'h1);
              if (s_r.bytes_left == 2'h0)
                s_nxt.st = spi_port_pkg::ST_DONE;
            end
          end
        spi_port_pkg::ST_DONE:
          s_nxt.st = spi_port_pkg::ST_DONE;
      endcase
      // read ends after the last bit has stood one full half period
      if (s_r.st == spi_port_pkg::ST_DATA && s_r.rd && rise &&
          s_r.bitn == 3'h0 && s_r.dout_en && s_r.bytes_left == 2'h3)
      begin
        s_nxt.st      = spi_port_pkg::ST_DONE;
        s_nxt.dout_en = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r      <= '0;
      s_r.sen_s <= 2'b11;
      s_r.regs[`SPO_ADDR*8 +: 8] <= `SPO_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************
  // pins and user side
  // ****************************************
  assign link.sdio_dev_o        = s_r.dout;
  assign link.sdio_dev_oe       = s_r.dout_en & ~four & ~sen_n;
  assign link.serial_out_line_o  = s_r.dout;
  assign link.serial_out_line_oe = s_r.dout_en & four & ~sen_n;
  assign o_reg_data  = s_r.regs[i_reg_addr*8 +: 8];
  assign o_four_wire = four;
  assign o_lsb_first = lsb;
  assign o_busy      = ~sen_n;

endmodule : spi_register_access_port

// ==== spi_link_assertions.sv ====
`timescale 1ns/1ns
module spi_link_assertions (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic serial_out_line_oe
);
  logic       sclk_q_r;
  logic       sel_q_r;
  logic [5:0] rise_cnt_r;
  wire        sclk_rise = sclk && !sclk_q_r;
  wire        dev_oe    = sdio_dev_oe || serial_out_line_oe;

  // ****************
  // frame bit counter
  // ****************
  // cleared at select fall, not rise: the device releases its pins a
  // few cycles after select rises, so the count must outlive the frame
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_q_r   <= 1'b0;
      sel_q_r    <= 1'b1;
      rise_cnt_r <= 6'h00;
    end
    else
    begin
      sclk_q_r <= sclk;
      sel_q_r  <= port_select_n;
      if (sel_q_r && !port_select_n)
        rise_cnt_r <= 6'h00;
      else if (sclk_rise)
        rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  property p_quiet_idle;
    port_select_n [*4] |-> !dev_oe;
  endproperty
  property p_one_out;
    dev_oe |-> !(sdio_dev_oe && serial_out_line_oe);
  endproperty
  property p_no_clash;
    sdio_dev_oe |-> !sdio_host_oe;
  endproperty
  property p_frame_len;
    $rose(port_select_n) |->
      rise_cnt_r inside {6'h10, 6'h18, 6'h20, 6'h28};
  endproperty
  property p_oe_after_hdr;
    dev_oe |-> rise_cnt_r >= 6'h08;
  endproperty
  property p_drive_start;
    $rose(dev_oe) |-> rise_cnt_r inside {6'h08, 6'h10, 6'h18, 6'h20};
  endproperty
  property p_sclk_in_frame;
    $rose(sclk) |-> !port_select_n;
  endproperty
  property p_sclk_half;
    $rose(sclk) |-> sclk [*4];
  endproperty

  a_quiet_idle: assert property (p_quiet_idle)
    else $error("pin driven while deselected");
  a_one_out: assert property (p_one_out)
    else $error("both device outputs driven");
  a_no_clash: assert property (p_no_clash)
    else $error("data line driven by both ends");
  a_frame_len: assert property (p_frame_len)
    else $error("frame bit count not header plus whole bytes");
  a_oe_after_hdr: assert property (p_oe_after_hdr)
    else $error("device drove before header complete");
  a_drive_start: assert property (p_drive_start)
    else $error("read data not on byte boundary");
  a_sclk_in_frame: assert property (p_sclk_in_frame)
    else $error("serial clock outside frame");
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase too short");

  c_sdio_read: cover property ($rose(sdio_dev_oe));
  c_four_read: cover property ($rose(serial_out_line_oe));
  c_long_frame: cover property ($rose(port_select_n) && rise_cnt_r == 6'h28);
endmodule : spi_link_assertions

// ==== spi_register_access_port_tb_top.sv ====
`timescale 1ns/1ns
module spi_register_access_port_tb_top;
  logic        mclk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_data;
  logic        four_wire;
  logic        lsb_first;
  logic        busy;
  logic [31:0] q;
  logic        e;
  int          err_total;
  int          n_tests;
  int          k;

  spi_link_if spi_link_if_i ();
  spi_register_access_port spi_register_access_port_i (
    .i_mclk      (mclk),
    .i_resetn    (resetn),
    .link        (spi_link_if_i),
    .i_reg_addr  (reg_addr),
    .o_reg_data  (reg_data),
    .o_four_wire (four_wire),
    .o_lsb_first (lsb_first),
    .o_busy      (busy)
  );
  spi_host_controller spi_host_controller_i (
    .i_mclk    (mclk),
    .i_resetn  (resetn),
    .link      (spi_link_if_i),
    .i_psel    (psel),
    .i_penable (penable),
    .i_pwrite  (pwrite),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr)
  );
  spi_link_assertions spi_link_assertions_i (
    .i_mclk             (mclk),
    .i_resetn           (resetn),
    .sclk               (spi_link_if_i.sclk),
    .port_select_n      (spi_link_if_i.port_select_n),
    .sdio_host_oe       (spi_link_if_i.sdio_host_oe),
    .sdio_dev_oe        (spi_link_if_i.sdio_dev_oe),
    .serial_out_line_oe (spi_link_if_i.serial_out_line_oe)
  );

  always #4 mclk = ~mclk;

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // one idle edge at the end so back-to-back calls never reassign psel
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic x);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic xfer(input logic [7:0] h, input logic [31:0] d,
                      input logic fw, input logic ls);
    logic [31:0] s;
    int          n;
    apb(1'b1, 12'h004, d, s, e);
    apb(1'b1, 12'h000, {1'b1, 21'h0, fw, ls, h}, s, e);
    n = 0;
    do
    begin
      apb(1'b0, 12'h00c, 32'h0, s, e);
      n++;
    end
    while (s[0] !== 1'b0 && n < 1000);
    chk({31'h0, s[0]}, 32'h0);
    apb(1'b0, 12'h008, 32'h0, q, e);
  endtask : xfer

  task automatic peek(input logic [4:0] a, input logic [7:0] x);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    chk({24'h0, reg_data}, {24'h0, x});
  endtask : peek

  // ****************
  // tests
  // ****************
  initial
  begin
    mclk      = 1'b0;
    resetn    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    reg_addr  = 5'h00;
    err_total = 0;
    n_tests   = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk({31'h0, four_wire}, 32'h0);
    peek(5'h00, 8'h00);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    xfer(8'h65, 32'h44332211, 1'b0, 1'b0);
    for (k = 0; k < 4; k++)
      peek(5'h05 - 5'(k), 8'h11 * 8'(k + 1));
    $display("test msb write done");
    xfer(8'hc4, 32'h0, 1'b0, 1'b0);
    chk(q & 32'h00ffffff, 32'h00443322);
    $display("test msb read done");
    xfer(8'h00, 32'h40, 1'b0, 1'b0);
    chk({31'h0, lsb_first}, 32'h1);
    xfer(8'h2a, 32'hbbaa, 1'b0, 1'b1);
    peek(5'h0a, 8'haa);
    peek(5'h0b, 8'hbb);
    xfer(8'haa, 32'h0, 1'b0, 1'b1);
    chk(q & 32'h0000ffff, 32'h0000bbaa);
    $display("test lsb done");
    xfer(8'h00, 32'hc0, 1'b0, 1'b1);
    chk({31'h0, four_wire}, 32'h1);
    xfer(8'h8b, 32'h0, 1'b1, 1'b1);
    chk(q & 32'h000000ff, 32'h000000bb);
    chk({31'h0, busy}, 32'h0);
    $display("test four wire done");
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : spi_register_access_port_tb_top
